/* shared/adc_frame_pkg.sv */
// Constants, types and layouts shared by the converter frame unit
package adc_frame_pkg;
   localparam int FRAME_BITS = 22;
   localparam int CNT_W      = 5;
   // Command opcodes in word bits 21..17
   localparam logic [4:0] OP_CLR = 5'h10;
   localparam logic [4:0] OP_RD  = 5'h11;
   localparam logic [4:0] OP_WR  = 5'h12;
   localparam logic [4:0] OP_SET = 5'h13;
   // Register addresses
   localparam logic [8:0] ADDR_CTRL = 9'h010;
   localparam logic [8:0] ADDR_PAT0 = 9'h011;
   localparam logic [8:0] ADDR_PAT1 = 9'h012;
   localparam logic [8:0] ADDR_PAT2 = 9'h013;
   // Output word control fields
   localparam int CTRL_PATSEL_BIT = 0;
   localparam int CTRL_PAREN_BIT  = 3;
   localparam int CTRL_RANGE_LSB  = 4;
   localparam logic [7:0]  RST_CTRL = 8'h00;
   localparam logic [19:0] RST_PAT  = 20'h00000;
   // Field parity masks over word bits 21..2
   localparam logic [19:0] PAR_MASK0 = 20'hc0000;
   localparam logic [19:0] PAR_MASK1 = 20'hf0000;
   localparam logic [19:0] PAR_MASK2 = 20'hff000;
   localparam logic [19:0] PAR_MASK3 = 20'hfffff;
   // Timing
   localparam int CLK_NS         = 5;
   localparam int T_CONV_NS      = 500;
   localparam int T_D_RST_NS     = 100;
   localparam int CONV_CYCLES    = (T_CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_DLY_CYCLES = (T_D_RST_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {ST_RESET, ST_ACQ, ST_CNV} state_t;
endpackage

/* hdl/adc_serial_frame_and_command_unit.sv */
`timescale 1ns/1ps
// Conversion sequencer, serial frame unit and command decoder
module adc_serial_frame_and_command_unit
   import adc_frame_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES,
   parameter int RST_CYC  = RST_DLY_CYCLES
) (
   input  wire logic        SYS_CLK,
   input  wire logic        NRST,
   input  wire logic        SCLK,
   input  wire logic        CS_N,
   input  wire logic        SDI,
   input  wire logic        CONVERSION_START,
   input  wire logic        PWR_DOWN,
   input  wire logic [19:0] CONV_RESULT,
   output logic             RDY,
   output logic             CONV_STATUS,
   output logic             SDO,
   output logic             SDO_OE
);

   if (CONV_CYC < 1 || CONV_CYC > 65535 || RST_CYC < 1 || RST_CYC > 65535) begin : g_chk
      $error("Cycle counts must lie in 1..65535");
   end

   state_t        state_r;
   state_t        state_nxt;
   logic [15:0]   cnt_r;
   logic          cs_s1_r, cs_s2_r, cs_s3_r;
   logic          cv_s1_r, cv_s2_r, cv_s3_r;
   logic          pd_s1_r, pd_s2_r;
   logic          tg_s1_r, tg_s2_r, tg_last_r;
   logic          frame_end, frame_start, cv_rise, conv_done;
   logic [19:0]   result_r;
   logic [7:0]    ctrl_r;
   logic [19:0]   pat_r;
   logic          rd_pend_r;
   logic [7:0]    rd_data_r;
   logic [21:0]   hold_word_r;
   logic [21:0]   word_nxt;
   logic [19:0]   d20;
   logic [19:0]   pmask;
   logic [4:0]    op;
   logic [8:0]    addr;
   logic [7:0]    dat;
   logic [7:0]    rd_val;
   logic [7:0]    mod_val;
   logic          do_cmd;
   // Serial clock domain
   logic          frame_rst_n;
   logic          started_r;
   logic          launched_r;
   logic          tgl_r;
   logic [21:0]   idr_r;
   logic [CNT_W-1:0] bitcnt_r;
   logic [21:0]   odr_r;
   logic          cnt_ok;

   // Pin synchronisers into the system clock domain
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_s3_r <= 1'b1;
         cv_s1_r <= 1'b0;
         cv_s2_r <= 1'b0;
         cv_s3_r <= 1'b0;
         pd_s1_r <= 1'b0;
         pd_s2_r <= 1'b0;
         tg_s1_r <= 1'b0;
         tg_s2_r <= 1'b0;
      end else begin
         cs_s1_r <= CS_N;
         cs_s2_r <= cs_s1_r;
         cs_s3_r <= cs_s2_r;
         cv_s1_r <= CONVERSION_START;
         cv_s2_r <= cv_s1_r;
         cv_s3_r <= cv_s2_r;
         pd_s1_r <= PWR_DOWN;
         pd_s2_r <= pd_s1_r;
         tg_s1_r <= tgl_r;
         tg_s2_r <= tg_s1_r;
      end
   end

   assign frame_end   = cs_s2_r & ~cs_s3_r;
   assign frame_start = ~cs_s2_r & cs_s3_r;
   assign cv_rise     = cv_s2_r & ~cv_s3_r;
   assign conv_done   = (state_r == ST_CNV) && (cnt_r == 16'(CONV_CYC - 1));

   // State sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET: begin
            if (cnt_r == 16'(RST_CYC - 1)) begin
               state_nxt = ST_ACQ;
            end
         end
         ST_ACQ: begin
            if (cv_rise && !pd_s2_r) begin
               state_nxt = ST_CNV;
            end
         end
         // start edges ignored until done; back to acquire
         ST_CNV: begin
            if (conv_done || pd_s2_r) begin
               state_nxt = ST_ACQ;
            end
         end
         default: begin
            state_nxt = ST_ACQ;
         end
      endcase
   end

   // reset lands in reset state, released into acquire
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         state_r <= ST_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Shared delay counter, cleared on each state change
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         cnt_r <= 16'h0000;
      end else if (state_nxt != state_r) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // Result latched only when a conversion completes
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         result_r <= 20'h00000;
      end else if (conv_done && !pd_s2_r) begin
         result_r <= CONV_RESULT;
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         CONV_STATUS <= 1'b0;
      end else begin
         CONV_STATUS <= (state_nxt == ST_ACQ);
      end
   end

   // ready low in frame, in reset, while converting
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         RDY <= 1'b0;
      end else begin
         RDY <= cs_s2_r && (state_nxt == ST_ACQ);
      end
   end

   // Command fields; readback of the addressed register
   always_comb begin
      op   = idr_r[21:17];
      addr = idr_r[16:8];
      dat  = idr_r[7:0];
      case (addr)
         ADDR_CTRL: rd_val = ctrl_r;
         ADDR_PAT0: rd_val = pat_r[7:0];
         ADDR_PAT1: rd_val = pat_r[15:8];
         ADDR_PAT2: rd_val = {4'h0, pat_r[19:16]};
         default:   rd_val = 8'h00;
      endcase
      // write, clear or set the masked bits
      case (op)
         OP_WR:   mod_val = dat;
         OP_CLR:  mod_val = rd_val & ~dat;
         OP_SET:  mod_val = rd_val | dat;
         default: mod_val = rd_val;
      endcase
   end

   // Input register and count are read here only after select has risen:
   // the link clock stands still then, so both are quiet across the crossing
   // decode only frames that clocked 22 or more bits
   assign do_cmd = frame_end && cnt_ok && (tg_s2_r != tg_last_r);

   // Frame toggle seen at frame end; a frame without edges is skipped
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         tg_last_r <= 1'b0;
      end else if (frame_end) begin
         tg_last_r <= tg_s2_r;
      end
   end

   // defaults on reset; other opcodes leave registers alone
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         ctrl_r <= RST_CTRL;
         pat_r  <= RST_PAT;
      end else if (do_cmd && (op == OP_WR || op == OP_CLR || op == OP_SET)) begin
         case (addr)
            ADDR_CTRL: ctrl_r <= mod_val;
            ADDR_PAT0: pat_r[7:0] <= mod_val;
            ADDR_PAT1: pat_r[15:8] <= mod_val;
            ADDR_PAT2: pat_r[19:16] <= mod_val[3:0];
            default: begin
            end
         endcase
      end
   end

   // read pending for the next frame, consumed at its start
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         rd_pend_r <= 1'b0;
         rd_data_r <= 8'h00;
      end else if (do_cmd && op == OP_RD) begin
         rd_pend_r <= 1'b1;
         rd_data_r <= rd_val;
      end else if (frame_start) begin
         rd_pend_r <= 1'b0;
      end
   end

   // Output word: pattern, then readback, then latest result
   always_comb begin
      case (ctrl_r[CTRL_RANGE_LSB +: 2])
         2'b00:   pmask = PAR_MASK0;
         2'b01:   pmask = PAR_MASK1;
         2'b10:   pmask = PAR_MASK2;
         default: pmask = PAR_MASK3;
      endcase
      if (ctrl_r[CTRL_PATSEL_BIT]) begin
         d20 = pat_r;
      end else if (rd_pend_r) begin
         d20 = {rd_data_r, 12'h000};
      end else begin
         d20 = result_r;
      end
      if (ctrl_r[CTRL_PAREN_BIT] && !(rd_pend_r && !ctrl_r[CTRL_PATSEL_BIT])) begin
         word_nxt = {d20, ^d20, ^(d20 & pmask)};
      end else begin
         word_nxt = {d20, 2'b00};
      end
   end

   // Word frozen while selected so the link side sees it quiet
   // The host must leave two system edges after select falls before launching
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         hold_word_r <= 22'h000000;
      end else if (cs_s2_r) begin
         hold_word_r <= word_nxt;
      end
   end

   // Link side: select high or reset clears frame state at once
   assign frame_rst_n = NRST & ~CS_N;

   // first capture edge of a frame marks the frame started
   always_ff @(negedge SCLK or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         started_r <= 1'b0;
      end else begin
         started_r <= 1'b1;
      end
   end

   // capture edge shifts input and counts, from zero per frame
   always_ff @(negedge SCLK or negedge NRST) begin
      if (!NRST) begin
         idr_r    <= 22'h000000;
         bitcnt_r <= '0;
         tgl_r    <= 1'b0;
      end else if (!started_r) begin
         idr_r    <= {21'h000000, SDI};
         bitcnt_r <= CNT_W'(1);
         tgl_r    <= ~tgl_r;
      end else begin
         idr_r <= {idr_r[20:0], SDI};
         if (bitcnt_r <= CNT_W'(FRAME_BITS)) begin
            bitcnt_r <= bitcnt_r + CNT_W'(1);
         end
      end
   end

   // Counter held still once the clock stops, read after select rises
   assign cnt_ok = (bitcnt_r >= CNT_W'(FRAME_BITS));

   // first launch loads word; later launches shift it
   always_ff @(posedge SCLK or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         launched_r <= 1'b0;
         odr_r      <= 22'h000000;
         SDO        <= 1'b0;
         SDO_OE     <= 1'b0;
      end else if (!launched_r) begin
         launched_r <= 1'b1;
         odr_r      <= {hold_word_r[20:0], 1'b0};
         SDO        <= hold_word_r[21];
         SDO_OE     <= 1'b1;
      end else begin
         odr_r <= {odr_r[20:0], 1'b0};
         SDO   <= odr_r[21];
      end
   end

   // Checks on the system clock side
   a_ready_frame: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      !cs_s2_r |=> !RDY)
      else $error("Ready high during a frame");
   a_conv_start: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (state_r == ST_ACQ && cv_rise && !pd_s2_r) |=> (state_r == ST_CNV) && !CONV_STATUS)
      else $error("Start edge did not begin a conversion");
   a_conv_hold: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (state_r == ST_CNV && !conv_done && !pd_s2_r) |=> (state_r == ST_CNV))
      else $error("Conversion left early");
   a_conv_end: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      conv_done |=> (state_r == ST_ACQ) && (cnt_r == 16'h0000))
      else $error("No acquire after conversion");
   a_write_ctrl: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (do_cmd && op == OP_WR && addr == ADDR_CTRL) |=> ctrl_r == $past(dat))
      else $error("Write command not applied");
   a_clear_bits: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (do_cmd && op == OP_CLR && addr == ADDR_CTRL) |=> ctrl_r == ($past(ctrl_r) & ~$past(dat)))
      else $error("Clear command wrong");
   a_short_nop: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (frame_end && !cnt_ok) |=> $stable(ctrl_r) && $stable(pat_r) && !rd_pend_r)
      else $error("Short frame acted");
   a_pattern_word: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (cs_s2_r && ctrl_r[CTRL_PATSEL_BIT]) |=> hold_word_r[21:2] == $past(pat_r))
      else $error("Pattern not in output word");
   a_parity_off: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (cs_s2_r && !ctrl_r[CTRL_PAREN_BIT]) |=> hold_word_r[1:0] == 2'b00)
      else $error("Parity bits not zero");
   a_reset_ready: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (state_r == ST_RESET) |-> !RDY)
      else $error("Ready high in reset");
   // Ready against status, power-down exit and the readback word
   a_ready_mirror: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      cs_s2_r |=> (RDY == CONV_STATUS))
      else $error("Ready does not follow status");
   a_power_down: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (state_r == ST_CNV && pd_s2_r) |=> (state_r == ST_ACQ) && CONV_STATUS)
      else $error("Power-down did not return to acquire");
   a_readback_word: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (cs_s2_r && rd_pend_r && !ctrl_r[CTRL_PATSEL_BIT])
      |=> hold_word_r == {$past(rd_data_r), 14'h0000})
      else $error("Readback word wrong");

   // Checks on the serial clock side
   a_first_bit: assert property (@(posedge SCLK) disable iff (!frame_rst_n)
      !launched_r |=> SDO_OE && (SDO == $past(hold_word_r[21])))
      else $error("First output bit wrong");

   c_write_cmd: cover property (@(posedge SYS_CLK) disable iff (!NRST)
      do_cmd && op == OP_WR);
   c_read_next: cover property (@(posedge SYS_CLK) disable iff (!NRST)
      rd_pend_r && frame_start);
   c_conv_done: cover property (@(posedge SYS_CLK) disable iff (!NRST)
      conv_done);
   c_power_down: cover property (@(posedge SYS_CLK) disable iff (!NRST)
      state_r == ST_CNV && pd_s2_r);
   c_short_frame: cover property (@(posedge SYS_CLK) disable iff (!NRST)
      frame_end && !cnt_ok);

endmodule

/* sim/host_ctrl.sv */
`timescale 1ns/1ps
// Host controller model: frames on the serial link and conversion starts
module host_ctrl (
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi,
   output logic      conversion_start,
   input  wire logic rdy,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   // Link clock stands low between frames
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
      conversion_start = 1'b0;
   end

   // Ready waits that ran out; the bench counts any number of them as one mismatch
   int stalls = 0;

   task automatic wait_ready();
      int i;
      for (i = 0; i < 4000 && rdy !== 1'b1; i++) #5;
      if (rdy !== 1'b1) stalls++;
      #20;
   endtask

   task automatic frame(input logic [31:0] cmd, input int n, output logic [21:0] rx,
                        output logic oe_ok);
      int i;
      rx = '0;
      oe_ok = 1'b1;
      cs_n = 1'b0;
      #40;
      for (i = n - 1; i >= 0; i--) begin
         sclk = 1'b1;
         sdi = cmd[i];
         #80;
         if (i >= n - 22) rx = {rx[20:0], sdo};
         oe_ok = oe_ok & (sdo_oe === 1'b1);
         sclk = 1'b0;
         #80;
      end
      sdi = ~sdi; // Released line shows no stale bit
      #40;
      cs_n = 1'b1;
      wait_ready();
   endtask

   // Optional second edge lands inside the conversion window
   task automatic convert(input logic retrig);
      conversion_start = 1'b1;
      #30;
      if (retrig) begin
         conversion_start = 1'b0;
         #20;
         conversion_start = 1'b1;
      end
      #20;
      conversion_start = 1'b0;
      wait_ready();
   endtask
endmodule

/* sim/adc_serial_frame_and_command_unit_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the converter frame and command unit
module adc_serial_frame_and_command_unit_test
   import adc_frame_pkg::*;
;
   logic        SYS_CLK, NRST, SCLK, CS_N, SDI, CONVERSION_START, PWR_DOWN;
   logic [19:0] CONV_RESULT;
   logic        RDY, CONV_STATUS, SDO, SDO_OE;
   logic [21:0] rx;
   logic        oe;
   int          err_count = 0;
   int          checks = 0;
   int          lo_cnt = 0;
   int          r;

   adc_serial_frame_and_command_unit #(.CONV_CYC(20), .RST_CYC(3))
      i_adc_serial_frame_and_command_unit (
      .SYS_CLK(SYS_CLK), .NRST(NRST), .SCLK(SCLK), .CS_N(CS_N), .SDI(SDI), .CONVERSION_START(CONVERSION_START),
      .PWR_DOWN(PWR_DOWN), .CONV_RESULT(CONV_RESULT), .RDY(RDY), .CONV_STATUS(CONV_STATUS),
      .SDO(SDO), .SDO_OE(SDO_OE));

   host_ctrl i_host_ctrl (.sclk(SCLK), .cs_n(CS_N), .sdi(SDI), .conversion_start(CONVERSION_START), .rdy(RDY),
      .sdo(SDO), .sdo_oe(SDO_OE));

   // System clock
   initial begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end

   // Width of the busy window, in system cycles
   always @(posedge SYS_CLK) if (CONV_STATUS === 1'b0) lo_cnt++;

   task automatic check(input logic [21:0] got, input logic [21:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
         err_count++;
      end
   endtask

   task automatic cmd(input logic [4:0] op, input logic [8:0] a, input logic [7:0] d);
      i_host_ctrl.frame({10'h0, op, a, d}, 22, rx, oe);
   endtask

   // Expected word; parity computed here, never by the design's own code
   function automatic logic [21:0] word(input logic [19:0] v, input logic p, input int rg);
      logic [19:0] m;
      m = (rg == 0) ? PAR_MASK0 : (rg == 1) ? PAR_MASK1 : (rg == 2) ? PAR_MASK2 : PAR_MASK3;
      return {v, p ? {^v, ^(v & m)} : 2'b00};
   endfunction

   task automatic results();
      $display("Checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Cut a hang short
   initial begin
      repeat (40000) @(posedge SYS_CLK);
      err_count++;
      $display("MISMATCH at %0t: run did not finish", $time);
      results();
   end

   initial begin
      NRST = 1'b0;
      PWR_DOWN = 1'b0;
      CONV_RESULT = 20'h12345;
      repeat (5) @(posedge SYS_CLK);
      #1 NRST = 1'b1;
      i_host_ctrl.wait_ready();
      check({20'h0, RDY, CONV_STATUS}, 22'h3, "idle after reset");
      lo_cnt = 0;
      i_host_ctrl.convert(1'b1);
      check(22'(lo_cnt), 22'd20, "busy width");
      @(posedge SYS_CLK) #1 CONV_RESULT = 20'hfffff;
      // Power-down in mid-conversion returns to acquire and keeps the old result
      lo_cnt = 0;
      fork
         i_host_ctrl.convert(1'b0);
         #40 PWR_DOWN = 1'b1;
      join
      check({21'h0, CONV_STATUS}, 22'h1, "acquire in power-down");
      check({21'h0, (lo_cnt > 0 && lo_cnt < 20)}, 22'h1, "conversion aborted");
      PWR_DOWN = 1'b0;
      cmd(5'h00, 9'h0, 8'h00);
      check(rx, word(20'h12345, 0, 0), "result word");
      check({20'h0, oe, SDO_OE}, 22'h2, "output enable");
      cmd(OP_WR, ADDR_PAT0, 8'ha5);
      cmd(OP_WR, ADDR_PAT1, 8'h3c);
      cmd(OP_WR, ADDR_PAT2, 8'hf7);
      cmd(OP_WR, ADDR_CTRL, 8'h01);
      cmd(OP_SET, ADDR_CTRL, 8'h08);
      check(rx, word(20'h73ca5, 0, 0), "pattern word");
      for (r = 0; r < 4; r++) begin
         if (r > 0) cmd(OP_WR, ADDR_CTRL, {2'b00, 2'(r), 4'h9});
         cmd(5'h00, 9'h0, 8'h00);
         check(rx, word(20'h73ca5, 1, r), "parity word");
      end
      cmd(OP_CLR, ADDR_CTRL, 8'h01);
      cmd(OP_RD, ADDR_CTRL, 8'h00);
      check(rx, word(20'h12345, 1, 3), "cleared pattern");
      cmd(OP_RD, 9'h1ff, 8'h00);
      check(rx, {8'h38, 14'h0}, "readback");
      cmd(5'h00, 9'h0, 8'h00);
      check(rx, 22'h0, "unmapped read");
      // No-operation codes and a reserved opcode leave control alone
      i_host_ctrl.frame(32'h0, 22, rx, oe);
      i_host_ctrl.frame(32'h3fffff, 22, rx, oe);
      cmd(5'h15, ADDR_CTRL, 8'h00);
      i_host_ctrl.frame({10'h0, OP_WR, ADDR_CTRL, 8'h00}, 20, rx, oe);
      check(rx, {2'b00, 20'h12345}, "short frame bits");
      cmd(OP_RD, ADDR_CTRL, 8'h00);
      cmd(5'h00, 9'h0, 8'h00);
      check(rx, {8'h38, 14'h0}, "control kept");
      i_host_ctrl.frame({6'h0, 4'hf, OP_WR, ADDR_CTRL, 8'h00}, 26, rx, oe);
      cmd(OP_WR, ADDR_CTRL, 8'h01);
      check(rx, word(20'h12345, 0, 0), "long frame");
      // Reset in mid-run restores defaults
      @(posedge SYS_CLK) #1 NRST = 1'b0;
      @(posedge SYS_CLK) #1;
      check({19'h0, RDY, CONV_STATUS, SDO_OE}, 22'h0, "held in reset");
      NRST = 1'b1;
      i_host_ctrl.wait_ready();
      check({21'h0, RDY}, 22'h1, "ready after reset");
      cmd(OP_RD, ADDR_CTRL, 8'h00);
      cmd(5'h00, 9'h0, 8'h00);
      check(rx, 22'h0, "control default");
      check(22'(i_host_ctrl.stalls), 22'h0, "ready waits");
      results();
   end
endmodule
